/* src/mmvd_pkg.sv */
// Constants and types shared by the memory map and vector decoder.
package mmvd_pkg;

   // ****************************************************************
   // Address map
   // ****************************************************************
   localparam int MMVD_ADDR_W = 16;
   localparam logic [15:0] MMVD_DP_HI = 16'h003F;
   localparam logic [15:0] MMVD_RAM_LO = 16'h0040;
   localparam logic [15:0] MMVD_RAM_HI = 16'h023F;
   localparam logic [15:0] MMVD_HP_LO = 16'h3000;
   localparam logic [15:0] MMVD_HP_HI = 16'h30FF;
   localparam logic [15:0] MMVD_EE_LO = 16'h3100;
   localparam logic [15:0] MMVD_EE_HI = 16'h317F;
   localparam logic [15:0] MMVD_VT_LO = 16'hFFB0;

   // ****************************************************************
   // Memory sizes
   // ****************************************************************
   localparam int MMVD_FLASH_BYTES = 4096;
   localparam int MMVD_FLASH_PAGE_BYTES = 512;
   localparam int MMVD_EE_PAGE_BYTES = 2;
   localparam int MMVD_OFS_W = 12;

   // ****************************************************************
   // Regions, one-hot
   // ****************************************************************
   typedef enum logic [6:0] {
      MMVD_R_NONE = 7'h01,
      MMVD_R_DPAGE = 7'h02,
      MMVD_R_RAM = 7'h04,
      MMVD_R_HPAGE = 7'h08,
      MMVD_R_EE = 7'h10,
      MMVD_R_FLASH = 7'h20,
      MMVD_R_VECT = 7'h40
   } mmvd_region_t;

   localparam mmvd_region_t MMVD_REGION_RST = MMVD_R_NONE;

   // ****************************************************************
   // Interrupt sources, in ascending vector order
   // ****************************************************************
   localparam int MMVD_NUM_SRC = 20;
   localparam int MMVD_SRC_W = 5;
   localparam logic [4:0] MMVD_SRC_NONCTRL = 5'h00;
   localparam logic [4:0] MMVD_SRC_RESET = 5'h13;

   // Index: nonvolatile_controller, keyboard_interrupt_unit, real time
   // counter, serial_comm_interface tx/rx/err, adc, analog_comparator,
   // first_timer_module ovf/ch1/ch0, second_timer_module ovf/ch1/ch0,
   // clock loss of lock, low voltage warning, watchdog, irq pin,
   // software_interrupt_instr, reset.
   localparam logic [15:0] MMVD_VEC_TAB [MMVD_NUM_SRC] = '{
      16'hFFB0, 16'hFFB4, 16'hFFB8, 16'hFFCC, 16'hFFCE,
      16'hFFD0, 16'hFFD2, 16'hFFD4, 16'hFFDA, 16'hFFDC,
      16'hFFDE, 16'hFFE0, 16'hFFE2, 16'hFFE4, 16'hFFF6,
      16'hFFF8, 16'hFFFA, 16'hFFFA, 16'hFFFC, 16'hFFFE
   };

   localparam logic [15:0] MMVD_VEC_RST = 16'hFFFE;

endpackage : mmvd_pkg

/* src/mmvd_decoder.sv */
// Memory map decoder and reset/interrupt vector selector for the core.
// Functional notes
// - Every 16-bit core address maps to exactly one region or unimplemented space.
// - Addresses 0x0000 through 0x003F select direct-page registers.
// - Addresses 0x3000 through 0x30FF select high-page registers.
// - 128-byte EEPROM at 0x3100-0x317F, 64 pages of two bytes.
// - Flash is 4096 bytes in 8 pages of 512 bytes.
// - Vector region spans 0xFFB0-0xFFFF, high byte even, low byte odd; pairs no source owns are reserved.
// - Reset fetches its start address from 0xFFFE:0xFFFF.
// - Software interrupt instruction vectors through 0xFFFC:0xFFFD.
// - IRQ pin and watchdog share 0xFFFA:0xFFFB; software finds the source.
// - Low-voltage warning uses 0xFFF8:0xFFF9.
// - Clock loss of lock uses 0xFFF6:0xFFF7.
// - Second timer: overflow 0xFFE0, channel 1 0xFFE2, channel 0 0xFFE4.
// - First timer: overflow 0xFFDA, channel 1 0xFFDC, channel 0 0xFFDE.
// - Serial interface: transmit 0xFFCC, receive 0xFFCE, error 0xFFD0.
// - ADC uses 0xFFD2, analog comparator uses 0xFFD4.
// - Nonvolatile controller 0xFFB0, keyboard 0xFFB4, real-time counter 0xFFB8.
`timescale 1ns/1ps
`default_nettype none

module mmvd_decoder
   import mmvd_pkg::*;
#(
   parameter int FLASH_BYTES = MMVD_FLASH_BYTES,
   parameter int FLASH_PAGE_BYTES = MMVD_FLASH_PAGE_BYTES,
   parameter int EE_PAGE_BYTES = MMVD_EE_PAGE_BYTES
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic [15:0] core_addr,
   input wire logic core_addr_valid,
   input wire logic [MMVD_NUM_SRC-1:0] int_req,
   output var mmvd_region_t region,
   output logic sel_valid,
   output logic [MMVD_OFS_W-1:0] region_offset,
   output logic [$clog2(FLASH_BYTES/FLASH_PAGE_BYTES)-1:0] flash_page,
   output logic [$clog2(128/EE_PAGE_BYTES)-1:0] eeprom_page,
   output logic pair_high_byte,
   output logic vec_reserved,
   output logic [15:0] vec_addr,
   output logic [MMVD_SRC_W-1:0] vec_src,
   output logic vec_valid
);

   // ****************************************************************
   // Derived sizes and elaboration checks
   // ****************************************************************
   localparam int FP_W = $clog2(FLASH_BYTES/FLASH_PAGE_BYTES);
   localparam int EP_W = $clog2(128/EE_PAGE_BYTES);
   localparam int FLASH_PAGE_SH = $clog2(FLASH_PAGE_BYTES);
   localparam int EE_PAGE_SH = $clog2(EE_PAGE_BYTES);
   // The flash base is derived so that the array always ends at the top.
   localparam logic [16:0] FLASH_LO_W = 17'h1_0000 - 17'(FLASH_BYTES);
   localparam logic [15:0] FLASH_LO = FLASH_LO_W[15:0];

   // Flash must stay clear of the EEPROM and still cover the vectors.
   if (FLASH_BYTES != (1 << $clog2(FLASH_BYTES))) begin : g_bad_flash_pow
      $error("FLASH_BYTES must be a power of two.");
   end
   if (FLASH_BYTES < 128 || FLASH_BYTES > 4096) begin : g_bad_flash
      $error("FLASH_BYTES must lie from 128 to 4096.");
   end
   if (FLASH_LO <= MMVD_EE_HI) begin : g_bad_flash_lo
      $error("Flash base must lie above the EEPROM.");
   end
   if (MMVD_OFS_W < $clog2(FLASH_BYTES)) begin : g_bad_ofs
      $error("Offset port is too narrow for the flash.");
   end
   if (MMVD_ADDR_W != 16) begin : g_bad_addr
      $error("The core address must be 16 bits wide.");
   end
   if (FLASH_PAGE_BYTES != (1 << FLASH_PAGE_SH)) begin : g_bad_fpage_pow
      $error("FLASH_PAGE_BYTES must be a power of two.");
   end
   if (FLASH_PAGE_BYTES > FLASH_BYTES / 2) begin : g_bad_fpage
      $error("FLASH_PAGE_BYTES must be at most half the flash.");
   end
   if (EE_PAGE_BYTES != (1 << EE_PAGE_SH) || EE_PAGE_BYTES > 64) begin : g_bad_epage
      $error("EE_PAGE_BYTES must be a power of two, at most 64.");
   end
   if (MMVD_VEC_TAB[MMVD_SRC_RESET] != MMVD_VEC_RST) begin : g_bad_rst_vec
      $error("The reset source must own the reset vector pair.");
   end
   // A table entry off its pair or outside the vector region would be fetched wrongly.
   for (genvar gi = 0; gi < MMVD_NUM_SRC; gi++) begin : g_vec_chk
      if (MMVD_VEC_TAB[gi][0] || MMVD_VEC_TAB[gi] < MMVD_VT_LO) begin : g_bad_vec
         $error("Vector table entries must be even and inside the vector region.");
      end
   end

   // ****************************************************************
   // Functions
   // ****************************************************************

   // Inclusive range test shared by the RAM, high-page and EEPROM regions.
   function automatic logic mmvd_in_range(input logic [15:0] a, input logic [15:0] lo, input logic [15:0] hi);
      return (a >= lo) && (a <= hi);
   endfunction : mmvd_in_range

   // Region decode; ranges are tested in order so no address hits two.
   function automatic mmvd_region_t mmvd_decode(input logic [15:0] a);
      mmvd_region_t r;
      r = MMVD_R_NONE;
      if (a <= MMVD_DP_HI) begin
         r = MMVD_R_DPAGE;
      end else if (mmvd_in_range(a, MMVD_RAM_LO, MMVD_RAM_HI)) begin
         r = MMVD_R_RAM;
      end else if (mmvd_in_range(a, MMVD_HP_LO, MMVD_HP_HI)) begin
         r = MMVD_R_HPAGE;
      end else if (mmvd_in_range(a, MMVD_EE_LO, MMVD_EE_HI)) begin
         r = MMVD_R_EE;
      end else if (a >= MMVD_VT_LO) begin
         r = MMVD_R_VECT;
      end else if (a >= FLASH_LO) begin
         r = MMVD_R_FLASH;
      end
      return r;
   endfunction : mmvd_decode

   // Base address that each region's offset is measured from.
   function automatic logic [15:0] mmvd_region_base(input mmvd_region_t r);
      logic [15:0] b;
      b = 16'h0000;
      unique case (r)
         MMVD_R_RAM: b = MMVD_RAM_LO;
         MMVD_R_HPAGE: b = MMVD_HP_LO;
         MMVD_R_EE: b = MMVD_EE_LO;
         MMVD_R_FLASH, MMVD_R_VECT: b = FLASH_LO;
         MMVD_R_DPAGE, MMVD_R_NONE: b = 16'h0000;
      endcase
      return b;
   endfunction : mmvd_region_base

   // Pair of each source; one item a line so each pair carries its rule.
   function automatic logic [15:0] mmvd_vec_pair(input logic [MMVD_SRC_W-1:0] s);
      logic [15:0] v;
      v = MMVD_VEC_RST;
      unique case (s)
         5'h00: v = MMVD_VEC_TAB[0];
         5'h01: v = MMVD_VEC_TAB[1];
         5'h02: v = MMVD_VEC_TAB[2];
         5'h03: v = MMVD_VEC_TAB[3];
         5'h04: v = MMVD_VEC_TAB[4];
         5'h05: v = MMVD_VEC_TAB[5];
         5'h06: v = MMVD_VEC_TAB[6];
         5'h07: v = MMVD_VEC_TAB[7];
         5'h08: v = MMVD_VEC_TAB[8];
         5'h09: v = MMVD_VEC_TAB[9];
         5'h0A: v = MMVD_VEC_TAB[10];
         5'h0B: v = MMVD_VEC_TAB[11];
         5'h0C: v = MMVD_VEC_TAB[12];
         5'h0D: v = MMVD_VEC_TAB[13];
         5'h0E: v = MMVD_VEC_TAB[14];
         5'h0F: v = MMVD_VEC_TAB[15];
         5'h10: v = MMVD_VEC_TAB[16];
         5'h11: v = MMVD_VEC_TAB[17];
         5'h12: v = MMVD_VEC_TAB[18];
         5'h13: v = MMVD_VEC_TAB[19];
         default: v = MMVD_VEC_RST;
      endcase
      return v;
   endfunction : mmvd_vec_pair

   // True when some source owns the vector pair holding this address.
   function automatic logic mmvd_slot_used(input logic [15:0] a);
      logic hit;
      logic [15:0] p;
      hit = 1'b0;
      for (int i = 0; i < MMVD_NUM_SRC; i++) begin
         p = mmvd_vec_pair(MMVD_SRC_W'(i));
         if (p[15:1] == a[15:1]) begin
            hit = 1'b1;
         end
      end
      return hit;
   endfunction : mmvd_slot_used

   // Highest pending index wins; the top bit of the result says whether any was pending.
   function automatic logic [MMVD_SRC_W:0] mmvd_pick(input logic [MMVD_NUM_SRC-1:0] req);
      logic [MMVD_SRC_W:0] p;
      p = {1'b0, MMVD_SRC_RESET};
      for (int i = 0; i < MMVD_NUM_SRC; i++) begin
         if (req[i]) begin
            p = {1'b1, MMVD_SRC_W'(i)};
         end
      end
      return p;
   endfunction : mmvd_pick

   // ****************************************************************
   // Region select
   // ****************************************************************
   mmvd_region_t next_region;
   logic next_sel_valid;

   // The address is decoded even when not valid; the user qualifies with sel_valid.
   always_comb begin
      next_region = mmvd_decode(core_addr);
      next_sel_valid = core_addr_valid;
   end

   // Reset values match an idle access to unmapped space.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         region <= MMVD_REGION_RST;
         sel_valid <= 1'b0;
      end else if (clk_en) begin
         region <= next_region;
         sel_valid <= next_sel_valid;
      end
   end

   // ****************************************************************
   // Position inside the region
   // ****************************************************************
   logic [MMVD_OFS_W-1:0] next_region_offset;
   logic [FP_W-1:0] next_flash_page;
   logic [EP_W-1:0] next_eeprom_page;
   logic next_pair_high_byte;
   logic next_vec_reserved;
   logic [15:0] base;
   logic [15:0] ofs;

   // Vector addresses keep flash offsets, so a flash image lines up with its pages.
   always_comb begin
      base = mmvd_region_base(next_region);
      ofs = core_addr - base;
      next_region_offset = ofs[MMVD_OFS_W-1:0];
      next_flash_page = '0;
      next_eeprom_page = '0;
      next_pair_high_byte = 1'b0;
      next_vec_reserved = 1'b0;
      if (next_region == MMVD_R_FLASH || next_region == MMVD_R_VECT) begin
         next_flash_page = ofs[FLASH_PAGE_SH +: FP_W];
      end
      if (next_region == MMVD_R_EE) begin
         next_eeprom_page = ofs[EE_PAGE_SH +: EP_W];
      end
      if (next_region == MMVD_R_VECT) begin
         next_pair_high_byte = ~core_addr[0];
         next_vec_reserved = ~mmvd_slot_used(core_addr);
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         region_offset <= '0;
         flash_page <= '0;
         eeprom_page <= '0;
         pair_high_byte <= 1'b0;
         vec_reserved <= 1'b0;
      end else if (clk_en) begin
         region_offset <= next_region_offset;
         flash_page <= next_flash_page;
         eeprom_page <= next_eeprom_page;
         pair_high_byte <= next_pair_high_byte;
         vec_reserved <= next_vec_reserved;
      end
   end

   // ****************************************************************
   // Vector selection
   // ****************************************************************
   // Sources are indexed in ascending vector order, so the last pending
   // one has the highest priority; reset therefore always wins.
   logic [15:0] next_vec_addr;
   logic [MMVD_SRC_W-1:0] next_vec_src;
   logic next_vec_valid;
   logic [MMVD_SRC_W:0] pick;

   // With nothing pending the reset source is named, so the reset pair is shown.
   always_comb begin
      pick = mmvd_pick(int_req);
      next_vec_valid = pick[MMVD_SRC_W];
      next_vec_src = pick[MMVD_SRC_W-1:0];
      // Only table entries are ever chosen, never a reserved pair.
      next_vec_addr = mmvd_vec_pair(next_vec_src);
   end

   // After reset the vector output already points at the reset pair.
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         vec_addr <= MMVD_VEC_RST;
         vec_src <= MMVD_SRC_RESET;
         vec_valid <= 1'b0;
      end else if (clk_en) begin
         vec_addr <= next_vec_addr;
         vec_src <= next_vec_src;
         vec_valid <= next_vec_valid;
      end
   end

endmodule : mmvd_decoder

`default_nettype wire

/* sim/mmvd_decoder_sva.sv */
// Port checker for the memory map and vector decoder.
`timescale 1ns/1ps
`default_nettype none
module mmvd_decoder_chk
   import mmvd_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic [15:0] core_addr,
   input wire logic core_addr_valid,
   input wire logic [MMVD_NUM_SRC-1:0] int_req,
   input wire mmvd_region_t region,
   input wire logic sel_valid,
   input wire logic [11:0] region_offset,
   input wire logic [2:0] flash_page,
   input wire logic [5:0] eeprom_page,
   input wire logic pair_high_byte,
   input wire logic vec_reserved,
   input wire logic [15:0] vec_addr,
   input wire logic [4:0] vec_src,
   input wire logic vec_valid
);
   // Inputs of the last edge, with en_q set when that edge was enabled; en_q stays low on the edge after reset so stale values are never judged.
   logic en_q;
   logic [15:0] a;
   logic [19:0] q;
   always_ff @(posedge mclk) begin
      en_q <= rst_n & clk_en;
      a <= core_addr;
      q <= int_req;
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   AST_DPAGE: assert property (en_q && a <= 16'h003F |-> region == MMVD_R_DPAGE) else $error("dp miss");
   AST_RAM: assert property (en_q && a >= 16'h0040 && a <= 16'h023F |-> region == MMVD_R_RAM &&
      region_offset == a[11:0] - 12'h040) else $error("ram miss");
   AST_HPAGE: assert property (en_q && a[15:8] == 8'h30 |-> region == MMVD_R_HPAGE) else $error("hp miss");
   AST_EEPROM: assert property (en_q && a >= 16'h3100 && a <= 16'h317F |-> region == MMVD_R_EE &&
      eeprom_page == a[6:1]) else $error("ee miss");
   AST_FLASH: assert property (en_q && a >= 16'hF000 && a < 16'hFFB0 |-> region == MMVD_R_FLASH &&
      flash_page == a[11:9]) else $error("flash miss");
   AST_VECT: assert property (en_q && a >= 16'hFFB0 |-> region == MMVD_R_VECT &&
      pair_high_byte == !a[0]) else $error("vector pair miss");
   AST_RESET_VEC: assert property (en_q && q == 20'h0_0000 |-> vec_addr == 16'hFFFE &&
      vec_src == 5'h13 && !vec_valid) else $error("idle vector wrong");
   AST_SWI: assert property (en_q && q[19:18] == 2'b01 |-> vec_addr == 16'hFFFC && vec_valid)
      else $error("swi vector wrong");
   AST_SHARED: assert property (en_q && q[19:18] == 2'b00 && q[17:16] != 2'b00 |-> vec_addr == 16'hFFFA)
      else $error("shared vector wrong");
   AST_FREEZE: assert property (!clk_en |=> $stable(region) && $stable(vec_addr)) else $error("not frozen");
   cover property (en_q && a >= 16'hFFB0 && vec_reserved);
   cover property (en_q && q[17:16] == 2'b11);
   cover property (!clk_en ##1 clk_en);
endmodule : mmvd_decoder_chk
`default_nettype wire

/* sim/mmvd_core_model.sv */
// Behavioural processor core presenting addresses to the decoder.
`timescale 1ns/1ps
`default_nettype none
module mmvd_core_model (
   input wire logic mclk,
   input wire logic [15:0] want_addr,
   input wire logic want_valid,
   output logic [15:0] core_addr,
   output logic core_addr_valid
);
   logic [15:0] held = 16'h0000;
   // An idle bus shows the inverse of the last address, so a stale address never looks right by luck.
   always_ff @(posedge mclk) begin
      core_addr_valid <= want_valid;
      held <= want_valid ? want_addr : ~held;
   end
   assign core_addr = held;
endmodule : mmvd_core_model
`default_nettype wire

/* sim/mmvd_decoder_bench.sv */
// Self-checking bench for the memory map and vector decoder.
`timescale 1ns/1ps
`default_nettype none
module mmvd_decoder_bench;
   localparam logic [15:0] VTAB [20] = '{16'hFFB0, 16'hFFB4, 16'hFFB8, 16'hFFCC, 16'hFFCE, 16'hFFD0, 16'hFFD2,
      16'hFFD4, 16'hFFDA, 16'hFFDC, 16'hFFDE, 16'hFFE0, 16'hFFE2, 16'hFFE4, 16'hFFF6, 16'hFFF8, 16'hFFFA,
      16'hFFFA, 16'hFFFC, 16'hFFFE};
   localparam logic [15:0] CORNER [14] = '{16'h0000, 16'h003F, 16'h0040, 16'h023F, 16'h0240, 16'h2FFF,
      16'h3000, 16'h30FF, 16'h3100, 16'h317F, 16'h3180, 16'hEFFF, 16'hF000, 16'hF1FF};
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic clk_en = 1'b1;
   logic [15:0] want_addr = 16'h0000;
   logic want_valid = 1'b0;
   logic [19:0] int_req = 20'h0_0000;
   logic [15:0] core_addr;
   logic core_addr_valid;
   mmvd_pkg::mmvd_region_t region;
   logic sel_valid, pair_high_byte, vec_reserved, vec_valid;
   logic [11:0] region_offset;
   logic [2:0] flash_page;
   logic [5:0] eeprom_page;
   logic [15:0] vec_addr;
   logic [4:0] vec_src;
   logic [52:0] e;
   logic go = 1'b0;
   int fails = 0;
   int check_count = 0;
   initial forever #25 mclk = ~mclk;
   mmvd_core_model core (.mclk(mclk), .want_addr(want_addr), .want_valid(want_valid), .core_addr(core_addr),
      .core_addr_valid(core_addr_valid));
   mmvd_decoder dut (.mclk(mclk), .rst_n(rst_n), .clk_en(clk_en), .core_addr(core_addr),
      .core_addr_valid(core_addr_valid), .int_req(int_req), .region(region), .sel_valid(sel_valid),
      .region_offset(region_offset), .flash_page(flash_page), .eeprom_page(eeprom_page),
      .pair_high_byte(pair_high_byte), .vec_reserved(vec_reserved), .vec_addr(vec_addr), .vec_src(vec_src),
      .vec_valid(vec_valid));
   function automatic logic [52:0] model(input logic [15:0] a, input logic v, input logic [19:0] r);
      logic [6:0] rg;
      logic [11:0] o;
      logic [4:0] s;
      logic rs;
      rg = 7'h01;
      if (a <= 16'h003F) rg = 7'h02;
      else if (a <= 16'h023F) rg = 7'h04;
      else if (a >= 16'h3000 && a <= 16'h30FF) rg = 7'h08;
      else if (a >= 16'h3100 && a <= 16'h317F) rg = 7'h10;
      else if (a >= 16'hFFB0) rg = 7'h40;
      else if (a >= 16'hF000) rg = 7'h20;
      o = (rg[0] | rg[1]) ? 12'h000 : a[11:0] - (rg[2] ? 12'h040 : rg[4] ? 12'h100 : 12'h000);
      s = 5'h13;
      rs = rg[6];
      for (int i = 0; i < 20; i++) begin
         if (r[i]) s = i[4:0];
         if (VTAB[i] == {a[15:1], 1'b0}) rs = 1'b0;
      end
      return {rg, v, o, (rg[5] | rg[6]) ? o[11:9] : 3'h0, rg[4] ? o[6:1] : 6'h00, rg[6] & ~a[0], rs, VTAB[s], s, |r};
   endfunction : model
   task automatic check(input logic [30:0] seen, input logic [30:0] want);
      check_count++;
      if (seen !== want) begin
         fails++;
         $display("ERROR at %0t: saw %h, expected %h", $time, seen, want);
      end
   endtask : check
   task automatic end_of_test();
      $display("Comparisons %0d, mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : end_of_test
   task automatic drive(input logic [15:0] a, input logic [19:0] r, input logic en);
      @(posedge mclk);
      want_addr <= a;
      want_valid <= 1'(($urandom % 4) != 0);
      int_req <= r;
      clk_en <= en;
   endtask : drive
   // Reset outputs equal those of an idle access to unmapped space.
   always @(posedge mclk) begin
      go <= 1'b1;
      if (!rst_n) e = model(16'h1000, 1'b0, 20'h0_0000);
      else if (clk_en) e = model(core_addr, core_addr_valid, int_req);
   end
   // Offsets of unmapped space and direct page are left open, so they are masked.
   always @(negedge mclk) begin
      if (go) begin
         check({region, sel_valid, (e[46] | e[47]) ? 12'h000 : region_offset, flash_page, eeprom_page,
            pair_high_byte, vec_reserved}, e[52:22]);
         check({9'h000, vec_addr, vec_src, vec_valid}, {9'h000, e[21:0]});
      end
   end
   initial begin
      void'($urandom(32'hA132));
      repeat (3) @(posedge mclk);
      rst_n <= 1'b1;
      foreach (CORNER[i]) drive(CORNER[i], 20'h0_0000, 1'b1);
      for (int i = 0; i < 82; i++) drive(16'hFFAE + 16'(i), 20'h0_0000, 1'b1);
      for (int i = 0; i < 20; i++) drive(16'(i), 20'h0_0001 << i, 1'b1);
      drive(16'h3100, 20'h3_0000, 1'b1);
      drive(16'h317F, 20'h0_0048, 1'b1);
      drive(16'h0200, 20'hF_FFFF, 1'b0);
      rst_n <= 1'b0;
      drive(16'hFFFE, 20'h0_0001, 1'b1);
      rst_n <= 1'b1;
      repeat (3000) drive(16'($urandom), (($urandom % 3) == 0) ? 20'($urandom) : 20'h0_0001 << ($urandom % 20),
         1'(($urandom % 8) != 0));
      end_of_test();
   end
endmodule : mmvd_decoder_bench
bind mmvd_decoder mmvd_decoder_chk chk (.mclk(mclk), .rst_n(rst_n), .clk_en(clk_en), .core_addr(core_addr),
   .core_addr_valid(core_addr_valid), .int_req(int_req), .region(region), .sel_valid(sel_valid),
   .region_offset(region_offset), .flash_page(flash_page), .eeprom_page(eeprom_page),
   .pair_high_byte(pair_high_byte), .vec_reserved(vec_reserved), .vec_addr(vec_addr), .vec_src(vec_src),
   .vec_valid(vec_valid));
`default_nettype wire
